// *** hw/sst_ctrl.sv ***
// System reference capture, multiframe clock alignment and sample timestamping.
// Assumes sysref_in and the monitor status arrive asynchronously; all else is on clk_sys_in.
`timescale 1ns/1ps

module sst_ctrl
  import sst_pkg::*;
#(
  parameter int CHANNELS = 4,
  parameter int SAMPLE_W = 16
) (
  input  wire logic                         clk_sys_in,
  input  wire logic                         reset_in,
  input  wire logic [11:0]                  reg_addr_in,
  input  wire logic [7:0]                   reg_wdata_in,
  input  wire logic                         reg_write_in,
  input  wire logic                         reg_read_in,
  output logic      [7:0]                   reg_rdata_out,
  input  wire logic                         sysref_in,
  input  wire logic [3:0]                   setup_status_in,
  input  wire logic [3:0]                   hold_status_in,
  input  wire logic                         frame_tick_in,
  input  wire logic [4:0]                   octets_per_frame_in,
  input  wire logic [5:0]                   frames_per_multiframe_in,
  input  wire logic [2:0]                   decimation_mode_in,
  input  wire logic [CHANNELS*SAMPLE_W-1:0] sample_in,
  input  wire logic                         sample_valid_in,
  output logic [CHANNELS*SAMPLE_W-1:0]      sample_out,
  output sst_sample_tag_type                sample_tag_out,
  output logic                              lmfc_out,
  output logic                              divider_reset_out,
  output logic [2:0]                        subclass_out
);

  generate
    if (CHANNELS < 1 || SAMPLE_W < 1) begin : bad_param_g
      $error("CHANNELS and SAMPLE_W must be at least 1.");
    end
  endgenerate

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  sst_sysref_cfg_type           sysref_cfg;
  logic [SST_IGNORE_W-1:0]      ignore_sel;
  logic [7:0]                   ts_delay;
  logic                         ts_mode;
  logic [7:0]                   func_low;
  logic [7:0]                   func_high;
  logic [SST_OFFSET_W-1:0]      lmfc_offset;
  logic [1:0]                   cbit_count;
  logic [2:0]                   subclass;
  logic                         sr_act;

  wire wr_ctrl = reg_write_in && reg_addr_in == SST_ADDR_SYSREF_CTRL;

  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      sysref_cfg  <= '0;
      ignore_sel  <= '0;
      ts_delay    <= '0;
      ts_mode     <= 1'b0;
      func_low    <= '0;
      func_high   <= '0;
      lmfc_offset <= '0;
      cbit_count  <= '0;
      subclass    <= SST_SUBCLASS_1;
    end else begin
      if (sr_act && sysref_cfg.mode == SST_MODE_NSHOT) begin
        sysref_cfg.mode <= SST_MODE_OFF;
      end
      if (reg_write_in) begin
        unique case (reg_addr_in)
          SST_ADDR_SYSREF_CTRL: begin
            sysref_cfg.trans_falling <= reg_wdata_in[SST_TRANS_BIT];
            sysref_cfg.edge_falling  <= reg_wdata_in[SST_EDGE_BIT];
            sysref_cfg.mode          <= reg_wdata_in[SST_MODE_LSB +: 2];
          end
          SST_ADDR_IGNORE:      ignore_sel  <= reg_wdata_in[SST_IGNORE_W-1:0];
          SST_ADDR_TS_DELAY:    ts_delay    <= reg_wdata_in;
          SST_ADDR_SYNC_MODE:   ts_mode     <= reg_wdata_in[SST_TS_MODE_BIT];
          SST_ADDR_FUNC_LOW:    func_low    <= reg_wdata_in;
          SST_ADDR_FUNC_HIGH:   func_high   <= reg_wdata_in;
          SST_ADDR_LMFC_OFFSET: lmfc_offset <= reg_wdata_in[SST_OFFSET_W-1:0];
          SST_ADDR_CBIT_COUNT:  cbit_count  <= reg_wdata_in[SST_CBIT_CNT_LSB +: 2];
          SST_ADDR_SUBCLASS:    subclass    <= reg_wdata_in[SST_SUBCLASS_LSB +: 3];
          default: begin
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Reference capture and monitor synchronisers
  // ----------------------------------------------------------------
  logic       sr_pos_meta;
  logic       sr_pos;
  logic       sr_neg_meta;
  logic       sr_neg;
  logic [7:0] mon_meta;
  logic [7:0] mon_sync;
  logic       sr_prev;
  logic       sr_sel;
  logic       sr_event;

  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      sr_pos_meta <= 1'b0;
      sr_pos      <= 1'b0;
      sr_neg      <= 1'b0;
      mon_meta    <= '0;
      mon_sync    <= '0;
    end else begin
      sr_pos_meta <= sysref_in;
      sr_pos      <= sr_pos_meta;
      sr_neg      <= sr_neg_meta;
      mon_meta    <= {hold_status_in, setup_status_in};
      mon_sync    <= mon_meta;
    end
  end

  // The falling-edge path gives half a clock period of extra capture phase.
  always_ff @(negedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      sr_neg_meta <= 1'b0;
    end else begin
      sr_neg_meta <= sysref_in;
    end
  end

  assign sr_sel = sysref_cfg.edge_falling ? sr_neg : sr_pos;

  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      sr_prev <= 1'b0;
    end else begin
      sr_prev <= sr_sel;
    end
  end

  assign sr_event = sysref_cfg.trans_falling ? (sr_prev && !sr_sel)
                                             : (!sr_prev && sr_sel);

  // ----------------------------------------------------------------
  // Event qualification and N-shot ignore counter
  // ----------------------------------------------------------------
  logic [SST_IGNORE_W-1:0] ign_cnt;
  logic                    realign;

  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      ign_cnt <= '0;
    end else if (wr_ctrl) begin
      ign_cnt <= '0;
    end else if (sr_event && sysref_cfg.mode == SST_MODE_NSHOT && ign_cnt != ignore_sel) begin
      ign_cnt <= ign_cnt + 1'b1;
    end
  end

  assign sr_act = sr_event && (sysref_cfg.mode == SST_MODE_CONT ||
                  (sysref_cfg.mode == SST_MODE_NSHOT && ign_cnt == ignore_sel));

  // Without Subclass 1 no event touches clocking; events still start timestamps when ts_mode is set and decimation is full bandwidth.
  assign realign = sr_act && !ts_mode && subclass == SST_SUBCLASS_1;

  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      divider_reset_out <= 1'b0;
    end else begin
      divider_reset_out <= realign;
    end
  end

  // ----------------------------------------------------------------
  // Local multiframe clock
  // ----------------------------------------------------------------
  logic [4:0]              frame_cnt;
  logic [SST_OFFSET_W-1:0] eff_delay;

  always_comb begin
    if (octets_per_frame_in == SST_OCTETS_ONE) begin
      eff_delay = lmfc_offset >> 2;
    end else if (octets_per_frame_in == SST_OCTETS_TWO) begin
      eff_delay = lmfc_offset >> 1;
    end else begin
      eff_delay = lmfc_offset;
    end
  end

  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      frame_cnt <= '0;
    end else if (realign) begin
      frame_cnt <= '0;
    end else if (frame_tick_in) begin
      if ({1'b0, frame_cnt} >= frames_per_multiframe_in - 6'h01) begin
        frame_cnt <= '0;
      end else begin
        frame_cnt <= frame_cnt + 5'h01;
      end
    end
  end

  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      lmfc_out <= 1'b0;
    end else begin
      lmfc_out <= frame_tick_in && !realign && frame_cnt == eff_delay;
    end
  end

  // ----------------------------------------------------------------
  // Timestamp marking
  // ----------------------------------------------------------------
  logic                 ts_pend;
  logic [7:0]           ts_cnt;
  logic                 ts_start;
  logic                 mark;
  logic [SST_CBITS-1:0] next_ctrl;
  logic [2:0]           func_sel [SST_CBITS];

  assign ts_start = sr_act && ts_mode && decimation_mode_in == SST_DEC_FULL_BW;
  assign mark     = ts_pend && sample_valid_in && ts_cnt == '0;

  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      ts_pend <= 1'b0;
      ts_cnt  <= '0;
    end else if (ts_start) begin
      ts_pend <= 1'b1;
      ts_cnt  <= ts_delay;
    end else if (ts_pend && sample_valid_in) begin
      if (ts_cnt == '0) begin
        ts_pend <= 1'b0;
      end else begin
        ts_cnt <= ts_cnt - 8'h01;
      end
    end
  end

  assign func_sel[0] = func_low[SST_FUNC0_LSB +: 3];
  assign func_sel[1] = func_low[SST_FUNC1_LSB +: 3];
  assign func_sel[2] = func_high[SST_FUNC2_LSB +: 3];

  genvar gi;
  generate
    for (gi = 0; gi < SST_CBITS; gi++) begin : cbit_g
      assign next_ctrl[gi] = mark && gi < cbit_count &&
                             func_sel[gi] == SST_FUNC_TIMESTAMP;
    end
  endgenerate

  // Every channel passes the same single register stage.
  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      sample_out     <= '0;
      sample_tag_out <= '0;
    end else begin
      sample_out           <= sample_in;
      sample_tag_out.valid <= sample_valid_in;
      sample_tag_out.ctrl  <= next_ctrl;
    end
  end

  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      subclass_out <= SST_SUBCLASS_1;
    end else begin
      subclass_out <= subclass;
    end
  end

  // ----------------------------------------------------------------
  // Register read port
  // ----------------------------------------------------------------
  logic [7:0] next_rdata;

  always_comb begin
    next_rdata = SST_REG_ZERO;
    if (reg_read_in) begin
      unique case (reg_addr_in)
        SST_ADDR_SYSREF_CTRL: begin
          next_rdata[SST_TRANS_BIT]      = sysref_cfg.trans_falling;
          next_rdata[SST_EDGE_BIT]       = sysref_cfg.edge_falling;
          next_rdata[SST_MODE_LSB +: 2]  = sysref_cfg.mode;
        end
        SST_ADDR_IGNORE:      next_rdata[SST_IGNORE_W-1:0] = ignore_sel;
        SST_ADDR_TS_DELAY:    next_rdata = ts_delay;
        SST_ADDR_MONITOR:     next_rdata = mon_sync;
        SST_ADDR_SYNC_MODE:   next_rdata[SST_TS_MODE_BIT] = ts_mode;
        SST_ADDR_FUNC_LOW:    next_rdata = func_low;
        SST_ADDR_FUNC_HIGH:   next_rdata = func_high;
        SST_ADDR_LMFC_OFFSET: next_rdata[SST_OFFSET_W-1:0] = lmfc_offset;
        SST_ADDR_CBIT_COUNT:  next_rdata[SST_CBIT_CNT_LSB +: 2] = cbit_count;
        SST_ADDR_SUBCLASS:    next_rdata[SST_SUBCLASS_LSB +: 3] = subclass;
        default:              next_rdata = SST_REG_ZERO;
      endcase
    end
  end

  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      reg_rdata_out <= '0;
    end else begin
      reg_rdata_out <= next_rdata;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (reset_in);

  subclass_hold_a: assert property (!(reg_write_in && reg_addr_in == SST_ADDR_SUBCLASS)
    |=> $stable(subclass) && subclass_out == $past(subclass))
    else $error("Subclass changed without a write.");
  subclass0_quiet_a: assert property (subclass == SST_SUBCLASS_0 |=> !divider_reset_out)
    else $error("Subclass 0 realigned the dividers.");
  realign_now_a: assert property (realign |=> divider_reset_out && frame_cnt == '0)
    else $error("Realign did not reset dividers and frame count.");
  ts_noclock_a: assert property (sr_act && ts_mode |=> !divider_reset_out)
    else $error("Timestamp mode reset the clocks.");
  lmfc_one_a: assert property (frame_tick_in && !realign && octets_per_frame_in == SST_OCTETS_ONE
    && frame_cnt == lmfc_offset[4:2] |=> lmfc_out)
    else $error("One-octet offset step wrong.");
  lmfc_two_a: assert property (frame_tick_in && !realign && octets_per_frame_in == SST_OCTETS_TWO
    && frame_cnt == lmfc_offset[4:1] |=> lmfc_out)
    else $error("Two-octet offset step wrong.");
  lmfc_other_a: assert property (lmfc_out && octets_per_frame_in > SST_OCTETS_TWO
    && $stable(octets_per_frame_in) |-> $past(frame_cnt) == $past(lmfc_offset))
    else $error("Multiframe clock not delayed by offset frames.");
  lmfc_tick_a: assert property (lmfc_out |-> $past(frame_tick_in))
    else $error("Multiframe clock boundary off a frame.");
  monitor_read_a: assert property (reg_read_in && reg_addr_in == SST_ADDR_MONITOR
    |=> reg_rdata_out == $past(mon_sync))
    else $error("Monitor readback wrong.");
  nshot_clear_a: assert property (sr_act && sysref_cfg.mode == SST_MODE_NSHOT && !wr_ctrl
    |=> sysref_cfg.mode == SST_MODE_OFF)
    else $error("N-shot mode did not clear.");
  decim_block_a: assert property (decimation_mode_in != SST_DEC_FULL_BW && !ts_pend
    |=> !ts_pend)
    else $error("Timestamp armed with decimation.");
  ts_delay_a: assert property (ts_start |=> ts_pend && ts_cnt == $past(ts_delay))
    else $error("Timestamp delay not loaded.");
  mark_once_a: assert property (sample_tag_out.ctrl != '0 |-> ($past(mark) && $past(sample_valid_in))
    ##1 (sample_tag_out.ctrl == '0 || $past(ts_start, 2)))
    else $error("Timestamp mark not single.");
  mark_func_a: assert property (sample_tag_out.ctrl[0] |-> $past(func_low[2:0]) == SST_FUNC_TIMESTAMP)
    else $error("Control bit 0 marked without timestamp function.");
  latency_a: assert property (sample_valid_in |=> sample_tag_out.valid && sample_out == $past(sample_in))
    else $error("Channel latency differs.");

endmodule

// *** hw/sst_pkg.sv ***
// Constants, register map and carrier types of the sysref sync and timestamp control block.
// Assumes a 12-bit register address and 8-bit register data.
package sst_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [11:0] SST_ADDR_SYSREF_CTRL = 12'h120;
  localparam logic [11:0] SST_ADDR_IGNORE      = 12'h121;
  localparam logic [11:0] SST_ADDR_TS_DELAY    = 12'h123;
  localparam logic [11:0] SST_ADDR_MONITOR     = 12'h128;
  localparam logic [11:0] SST_ADDR_SYNC_MODE   = 12'h1ff;
  localparam logic [11:0] SST_ADDR_FUNC_LOW    = 12'h559;
  localparam logic [11:0] SST_ADDR_FUNC_HIGH   = 12'h55a;
  localparam logic [11:0] SST_ADDR_LMFC_OFFSET = 12'h578;
  localparam logic [11:0] SST_ADDR_CBIT_COUNT  = 12'h58f;
  localparam logic [11:0] SST_ADDR_SUBCLASS    = 12'h590;

  // ----------------------------------------------------------------
  // Field positions and encodings
  // ----------------------------------------------------------------
  localparam int          SST_SUBCLASS_LSB   = 5;
  localparam logic [2:0]  SST_SUBCLASS_0     = 3'h0;
  localparam logic [2:0]  SST_SUBCLASS_1     = 3'h1;
  localparam int          SST_TRANS_BIT      = 4;
  localparam int          SST_EDGE_BIT       = 3;
  localparam int          SST_MODE_LSB       = 1;
  localparam logic [1:0]  SST_MODE_OFF       = 2'h0;
  localparam logic [1:0]  SST_MODE_CONT      = 2'h1;
  localparam logic [1:0]  SST_MODE_NSHOT     = 2'h2;
  localparam int          SST_TS_MODE_BIT    = 0;
  localparam int          SST_CBIT_CNT_LSB   = 6;
  localparam int          SST_FUNC0_LSB      = 0;
  localparam int          SST_FUNC1_LSB      = 4;
  localparam int          SST_FUNC2_LSB      = 0;
  localparam logic [2:0]  SST_FUNC_TIMESTAMP = 3'h5;
  localparam int          SST_IGNORE_W       = 4;
  localparam int          SST_OFFSET_W       = 5;
  localparam int          SST_CBITS          = 3;
  localparam logic [2:0]  SST_DEC_FULL_BW    = 3'h0;
  localparam logic [4:0]  SST_OCTETS_ONE     = 5'h01;
  localparam logic [4:0]  SST_OCTETS_TWO     = 5'h02;
  localparam logic [7:0]  SST_REG_ZERO       = 8'h00;

  // ----------------------------------------------------------------
  // Carrier types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic                 valid;
    logic [SST_CBITS-1:0] ctrl;
  } sst_sample_tag_type;

  typedef struct packed {
    logic       trans_falling;
    logic       edge_falling;
    logic [1:0] mode;
  } sst_sysref_cfg_type;

endpackage

// *** verif/sst_link_rx_model.sv ***
// Link receiver model: counts timestamp marks and releases buffered data on multiframe boundaries.
// Assumes it watches the block's sample outputs in the same clock domain.
`timescale 1ns/1ps
module sst_link_rx_model
  import sst_pkg::*;
(
  input  wire logic               clk_sys_in,
  input  wire logic               reset_in,
  input  wire logic               lmfc_in,
  input  wire sst_sample_tag_type tag_in,
  input  wire logic [63:0]        sample_in,
  output int                      marks_out,
  output logic [63:0]             release_out
);
  logic [63:0] buffer;

  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      marks_out   <= 0;
      buffer      <= '0;
      release_out <= '0;
    end else begin
      if (|tag_in.ctrl) marks_out <= marks_out + 1;
      if (tag_in.valid) buffer <= sample_in;
      if (lmfc_in) release_out <= buffer;
    end
  end
endmodule

// *** verif/sst_ctrl_tb.sv ***
// Self-checking bench of the sysref sync and timestamp control block.
// Assumes the block and the receiver model share one 40 MHz clock.
`timescale 1ns/1ps
module sst_ctrl_tb
  import sst_pkg::*;
;
  // ----------------------------------------------------------------
  // Stimulus and monitors
  // ----------------------------------------------------------------
  logic               clk = 0, rst = 1, wr_en = 0, rd_en = 0, sysref = 0, tick = 0, lmfc, dres;
  logic               vld = 1'b1, vld_q, rnd_vld = 1'b0;
  logic [11:0]        addr = '0;
  logic [7:0]         wdata = '0, rdata;
  logic [3:0]         setup_st = '0, hold_st = '0;
  logic [4:0]         opf = 5'h04;
  logic [2:0]         dec = 3'h0, subclass, mark_ctrl;
  logic [63:0]        smp = '0, smp_q, smp_out, rx_rel;
  sst_sample_tag_type tag;
  int                 mismatches = 0, n_checks = 0, seed = 91219, cyc = 0, ticks = 0;
  int                 n_dr = 0, dr_cyc = 0, mark_cyc = 0, lmfc_ph = 0, rx_marks;

  sst_ctrl #(.CHANNELS(4), .SAMPLE_W(16)) u_sst_ctrl (
    .clk_sys_in(clk), .reset_in(rst), .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_write_in(wr_en),
    .reg_read_in(rd_en), .reg_rdata_out(rdata), .sysref_in(sysref), .setup_status_in(setup_st),
    .hold_status_in(hold_st), .frame_tick_in(tick), .octets_per_frame_in(opf),
    .frames_per_multiframe_in(6'd32), .decimation_mode_in(dec), .sample_in(smp), .sample_valid_in(vld),
    .sample_out(smp_out), .sample_tag_out(tag), .lmfc_out(lmfc), .divider_reset_out(dres),
    .subclass_out(subclass));

  sst_link_rx_model u_sst_link_rx_model (
    .clk_sys_in(clk), .reset_in(rst), .lmfc_in(lmfc), .tag_in(tag), .sample_in(smp_out),
    .marks_out(rx_marks), .release_out(rx_rel));

  always #12.5 clk = ~clk;

  always @(posedge clk) begin
    cyc   <= cyc + 1;
    tick  <= ~tick;
    ticks <= ticks + int'(tick);
    smp   <= {$random(seed), $random(seed)};
    smp_q <= smp;
    vld   <= rnd_vld ? 1'($random(seed)) : 1'b1;
    vld_q <= vld;
  end

  always @(posedge clk) begin
    #1;
    if (dres === 1'b1) begin
      n_dr++;
      dr_cyc = cyc;
    end
    if (|tag.ctrl) begin
      mark_cyc  = cyc;
      mark_ctrl = tag.ctrl;
      chk(smp_out, smp_q);
    end
    if (lmfc === 1'b1) lmfc_ph = ticks % 32;
    if (cyc > 4) begin
      chk(tag.valid, vld_q);
      chk(smp_out, smp_q);
    end
  end

  // ----------------------------------------------------------------
  // Tasks and expectations
  // ----------------------------------------------------------------
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t got %0h exp %0h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask

  task automatic rc(input logic [11:0] a, input logic [7:0] exp);
    @(posedge clk);
    addr  <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1 chk(rdata, exp);
  endtask

  task automatic pulse(output int rise, output int fall);
    @(posedge clk);
    for (int k = 0; k < 64 && cyc % 64 != 0; k++) @(posedge clk);
    sysref <= 1'b1;
    rise = cyc;
    repeat (8) @(posedge clk);
    sysref <= 1'b0;
    fall = cyc;
    repeat (12) @(posedge clk);
  endtask

  task automatic meas(input logic [7:0] o, output int ph);
    int n;
    n = 0;
    wr(SST_ADDR_LMFC_OFFSET, o);
    for (int k = 0; k < 300 && n < 2; k++) begin
      @(posedge clk);
      #2 n += int'(lmfc === 1'b1);
    end
    if (n < 2) begin
      mismatches++;
      end_of_test();
    end
    ph = lmfc_ph;
  endtask

  function automatic int eff(input int f, input int o);
    return f == 1 ? o >> 2 : f == 2 ? o >> 1 : o;
  endfunction

  function automatic logic [2:0] exp_ctrl(input int cnt, input logic [7:0] lo, input logic [7:0] hi);
    logic [2:0] f;
    f = {hi[2:0] == SST_FUNC_TIMESTAMP, lo[6:4] == SST_FUNC_TIMESTAMP, lo[2:0] == SST_FUNC_TIMESTAMP};
    return f & 3'((1 << cnt) - 1);
  endfunction

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (100000) @(posedge clk);
    mismatches++;
    end_of_test();
  end

  initial begin
    logic [7:0] v, lo;
    int r, f, n0, m0, ph0, ph1, cnt, lat0;
    setup_st = 4'($random(seed));
    hold_st  = 4'($random(seed));
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    chk(subclass, 3'h1);
    rc(SST_ADDR_SUBCLASS, 8'h20);
    rc(SST_ADDR_SYNC_MODE, 8'h00);
    rc(12'h7ff, 8'h00);
    rc(SST_ADDR_MONITOR, {hold_st, setup_st});
    v = 8'($random(seed));
    wr(SST_ADDR_TS_DELAY, v);
    rc(SST_ADDR_TS_DELAY, v);
    for (int i = 0; i < 4; i++) begin
      wr(SST_ADDR_SYSREF_CTRL, 8'(i << 3) | 8'h02);
      n0 = n_dr;
      pulse(r, f);
      chk(n_dr - n0, 1);
      chk(dr_cyc > f, i[1]);
    end
    wr(SST_ADDR_SUBCLASS, 8'h00);
    n0 = n_dr;
    pulse(r, f);
    chk(n_dr - n0, 0);
    chk(subclass, 3'h0);
    wr(SST_ADDR_SUBCLASS, 8'h20);
    wr(SST_ADDR_IGNORE, 8'h02);
    wr(SST_ADDR_SYSREF_CTRL, 8'h04);
    n0 = n_dr;
    for (int i = 0; i < 3; i++) begin
      pulse(r, f);
      chk(n_dr - n0, i / 2);
    end
    rc(SST_ADDR_SYSREF_CTRL, 8'h00);
    pulse(r, f);
    chk(n_dr - n0, 1);
    rnd_vld <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      opf <= 5'(1 << i);
      v = i == 0 ? 8'h1f : 8'($random(seed)) & 8'h1f;
      meas(8'h00, ph0);
      meas(v, ph1);
      chk((ph1 - ph0 + 32) % 32, eff(1 << i, v));
    end
    rnd_vld <= 1'b0;
    wr(SST_ADDR_SYNC_MODE, 8'h01);
    wr(SST_ADDR_SYSREF_CTRL, 8'h02);
    n0 = n_dr;
    for (int i = 0; i < 4; i++) begin
      cnt = i == 3 ? 3 : i + 1;
      lo = i == 3 ? 8'h50 : 8'h55;
      wr(SST_ADDR_CBIT_COUNT, 8'(cnt << 6));
      wr(SST_ADDR_FUNC_LOW, lo);
      wr(SST_ADDR_FUNC_HIGH, 8'h05);
      wr(SST_ADDR_TS_DELAY, 8'(i));
      m0 = rx_marks;
      pulse(r, f);
      chk(rx_marks - m0, 1);
      chk(mark_ctrl, exp_ctrl(cnt, lo, 8'h05));
      if (i == 0) lat0 = mark_cyc - r;
      chk(mark_cyc - r - lat0, i);
      chk(mark_cyc - r < 64, 1);
    end
    chk(n_dr - n0, 0);
    dec <= 3'h1;
    m0 = rx_marks;
    pulse(r, f);
    chk(rx_marks - m0, 0);
    end_of_test();
  end
endmodule
